// ===== design/frc_pkg.sv
package frc_pkg;
	localparam logic       MODE_SPI        = 1'b0;
	localparam logic       MODE_PARALLEL   = 1'b1;
	localparam logic       RST_MODE        = 1'b0;
	localparam logic       RST_RECONFIG    = 1'b0;
	localparam logic       RST_ISP         = 1'b0;
	localparam logic       RST_LINK        = 1'b1;
	localparam logic [1:0] RST_M_PINS      = 2'h1;
	localparam logic [1:0] M_PINS_SPI      = 2'h1;
	localparam logic [1:0] M_PINS_PARALLEL = 2'h2;
	localparam int         SYNC_STAGES     = 3;
	localparam int         STAT_BITS       = 2;
	localparam int         STAT_DONE       = 0;
	localparam int         STAT_INIT       = 1;
	typedef enum logic [2:0] {
		FRC_BOOT    = 3'h1,
		FRC_HOLD    = 3'h2,
		FRC_RUN     = 3'h4
	} frc_state_t;
endpackage

// ===== design/frc_sync_if.sv
interface frc_sync_if;
	logic [frc_pkg::STAT_BITS-1:0] raw;
	logic [frc_pkg::STAT_BITS-1:0] level;
	modport sync (input raw, output level);
	modport user (output raw, input level);
endinterface

// ===== design/frc_pin_sync.sv
module frc_pin_sync (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Pins in, filtered levels out
	frc_sync_if.sync  sif
);
	logic [frc_pkg::STAT_BITS-1:0] s1;
	logic [frc_pkg::STAT_BITS-1:0] s2;
	logic [frc_pkg::STAT_BITS-1:0] s3;
	logic [frc_pkg::STAT_BITS-1:0] lvl;

	assign sif.level = lvl;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= sif.raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A level is taken only once two late stages agree
	genvar i;
	generate
		for (i = 0; i < frc_pkg::STAT_BITS; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					lvl[i] <= 1'b0;
				end else if (s2[i] == s3[i]) begin
					lvl[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule

// ===== design/frc_top.sv
module frc_top (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Host control bits
	input  wire logic       target_cfg_mode_sel,
	input  wire logic       target_reconfig_cmd,
	input  wire logic       insystem_prog_enable,
	input  wire logic       endpoint_link_enable,
	// Host status bits
	output logic            target_cfg_mode_rd,
	output logic            target_reconfig_rd,
	output logic            insystem_prog_rd,
	output logic            endpoint_link_enable_rd,
	output logic            target_done_status,
	output logic            target_init_status,
	// Target configuration pins
	input  wire logic       target_done_pin,
	input  wire logic       target_init_pin,
	output logic            target_prog_b,
	output logic [1:0]      target_mode_pins,
	output logic            target_io_hiz,
	output logic            target_flash_owner,
	// Switch link and board
	output logic            link_enable,
	output logic            done_led
);
	frc_pkg::frc_state_t state;
	frc_pkg::frc_state_t next_state;
	logic                 cmd_q;
	logic                 cmd_fall;
	frc_sync_if           sif ();

	assign sif.raw[frc_pkg::STAT_DONE] = target_done_pin;
	assign sif.raw[frc_pkg::STAT_INIT] = target_init_pin;

	frc_pin_sync u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.sif     (sif)
	);

	// Registered copies of host controls
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			insystem_prog_rd        <= frc_pkg::RST_ISP;
			target_cfg_mode_rd      <= frc_pkg::RST_MODE;
			endpoint_link_enable_rd <= frc_pkg::RST_LINK;
			link_enable             <= frc_pkg::RST_LINK;
			target_reconfig_rd      <= frc_pkg::RST_RECONFIG;
			cmd_q                   <= frc_pkg::RST_RECONFIG;
		end else if (state == frc_pkg::FRC_BOOT) begin
			cmd_q <= frc_pkg::RST_RECONFIG;
		end else begin
			insystem_prog_rd        <= insystem_prog_enable;
			target_cfg_mode_rd      <= target_cfg_mode_sel;
			endpoint_link_enable_rd <= endpoint_link_enable;
			link_enable             <= endpoint_link_enable;
			target_reconfig_rd      <= target_reconfig_cmd;
			cmd_q                   <= target_reconfig_cmd;
		end
	end

	assign cmd_fall = cmd_q && !target_reconfig_cmd;

	always_comb begin
		next_state = state;
		case (state)
			frc_pkg::FRC_BOOT: begin
				next_state = frc_pkg::FRC_RUN;
			end
			frc_pkg::FRC_RUN: begin
				if (target_reconfig_cmd) begin
					next_state = frc_pkg::FRC_HOLD;
				end
			end
			frc_pkg::FRC_HOLD: begin
				if (cmd_fall) begin
					next_state = frc_pkg::FRC_RUN;
				end
			end
			default: begin
				next_state = frc_pkg::FRC_BOOT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= frc_pkg::FRC_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// Pin drive; mode pins only change while held so a load never sees a swap
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			target_mode_pins   <= frc_pkg::RST_M_PINS;
			target_prog_b      <= 1'b1;
			target_io_hiz      <= 1'b0;
			target_flash_owner <= 1'b0;
		end else begin
			target_prog_b      <= (next_state != frc_pkg::FRC_HOLD);
			target_io_hiz      <= (next_state == frc_pkg::FRC_HOLD);
			target_flash_owner <= (state != frc_pkg::FRC_BOOT) && insystem_prog_enable;
			if (state == frc_pkg::FRC_BOOT) begin
				target_mode_pins <= frc_pkg::M_PINS_SPI;
			end else if (state == frc_pkg::FRC_HOLD) begin
				target_mode_pins <= (target_cfg_mode_sel == frc_pkg::MODE_PARALLEL)
					? frc_pkg::M_PINS_PARALLEL : frc_pkg::M_PINS_SPI;
			end
		end
	end

	// Status from filtered pins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			target_done_status <= 1'b0;
			target_init_status <= 1'b0;
			done_led           <= 1'b0;
		end else begin
			target_done_status <= sif.level[frc_pkg::STAT_DONE];
			done_led           <= sif.level[frc_pkg::STAT_DONE];
			target_init_status <= sif.level[frc_pkg::STAT_INIT];
		end
	end

	// Program and high-Z pins are registered from next_state, so they already match the state they enter with
	AST_HOLD_HIZ: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_HOLD |-> target_io_hiz && !target_prog_b)
		else $error("hold state without high-Z and program");
	AST_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == frc_pkg::FRC_HOLD && cmd_fall) |=> target_prog_b && !target_io_hiz)
		else $error("reload not started on command fall");
	AST_PROG_ACTIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == frc_pkg::FRC_RUN && target_reconfig_cmd) |=> !target_prog_b)
		else $error("program not asserted on command");
	AST_DONE_LED: assert property (@(posedge clk_sys) disable iff (!rst_b)
		done_led == target_done_status)
		else $error("done LED differs from status");
	AST_DONE_LAT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(target_done_pin) ##1 target_done_pin [*5] |-> ##0 target_done_status)
		else $error("done status late");
	AST_INIT_LAT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(target_init_pin) ##1 !target_init_pin [*5] |-> ##0 !target_init_status)
		else $error("init status late");
	AST_LINK: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_RUN ##1 1'b1 |-> link_enable == $past(endpoint_link_enable))
		else $error("link enable not followed");
	AST_MODE_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == frc_pkg::FRC_RUN && $past(state) == frc_pkg::FRC_RUN)
		|-> $stable(target_mode_pins))
		else $error("mode pins moved outside hold");
	AST_BOOT_SPI: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_BOOT |=> target_mode_pins == frc_pkg::M_PINS_SPI)
		else $error("boot did not force SPI mode pins");
	AST_MODE_PAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == frc_pkg::FRC_HOLD && target_cfg_mode_sel == frc_pkg::MODE_PARALLEL)
		|=> target_mode_pins == frc_pkg::M_PINS_PARALLEL)
		else $error("parallel mode not applied in hold");
	AST_MODE_SPI: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == frc_pkg::FRC_HOLD && target_cfg_mode_sel == frc_pkg::MODE_SPI)
		|=> target_mode_pins == frc_pkg::M_PINS_SPI)
		else $error("SPI mode not applied in hold");
	AST_HIZ_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		target_io_hiz == !target_prog_b)
		else $error("high-Z and program disagree");
	AST_OWNER: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state != frc_pkg::FRC_BOOT |=> target_flash_owner == $past(insystem_prog_enable))
		else $error("flash owner does not follow ISP enable");
	AST_LINK_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_RUN |=> endpoint_link_enable_rd == $past(endpoint_link_enable))
		else $error("link readback wrong");
	AST_CMD_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_RUN |=> target_reconfig_rd == $past(target_reconfig_cmd))
		else $error("reconfigure readback wrong");
	AST_MODE_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_RUN |=> target_cfg_mode_rd == $past(target_cfg_mode_sel))
		else $error("mode readback wrong");
	AST_ISP_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_RUN |=> insystem_prog_rd == $past(insystem_prog_enable))
		else $error("ISP readback wrong");

	COV_RELOAD: cover property (@(posedge clk_sys) disable iff (!rst_b)
		state == frc_pkg::FRC_HOLD ##1 state == frc_pkg::FRC_RUN);
	COV_PARALLEL: cover property (@(posedge clk_sys) disable iff (!rst_b)
		target_mode_pins == frc_pkg::M_PINS_PARALLEL);
	COV_DONE: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(target_done_status));
	COV_INIT_LOW: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(target_init_status));
endmodule

// ===== tb/frc_target_model.sv
module frc_target_model #(
	parameter int LOAD_CYCLES = 20
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Configuration pins from the controller
	input  wire logic       target_prog_b,
	input  wire logic [1:0] target_mode_pins,
	// Status pins back to the controller
	output logic            target_done_pin,
	output logic            target_init_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// program low clears the target and restarts loading
	// done only after a full flash load; parallel mode gets no data here
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt             <= 0;
			target_done_pin <= 1'b0;
			target_init_pin <= 1'b0;
		end else if (!target_prog_b) begin
			cnt             <= 0;
			target_done_pin <= 1'b0;
			target_init_pin <= 1'b0;
		end else begin
			target_init_pin <= 1'b1;
			if (cnt < LOAD_CYCLES) begin
				cnt <= cnt + 1;
			end
			target_done_pin <= (cnt == LOAD_CYCLES) && (target_mode_pins === frc_pkg::M_PINS_SPI);
		end
	end
endmodule

// ===== tb/frc_top_bench.sv
module frc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys, rst_b, mode_sel, cmd, isp, link, done_pin, init_pin;
	logic       mode_rd, cmd_rd, isp_rd, link_rd, done_st, init_st;
	logic       prog_b, hiz, owner, link_en, led;
	logic [1:0] mpins;
	int         bad_count, total_checks;

	frc_top i_frc_top (.clk_sys(clk_sys), .rst_b(rst_b), .target_cfg_mode_sel(mode_sel),
		.target_reconfig_cmd(cmd), .insystem_prog_enable(isp), .endpoint_link_enable(link),
		.target_cfg_mode_rd(mode_rd), .target_reconfig_rd(cmd_rd), .insystem_prog_rd(isp_rd),
		.endpoint_link_enable_rd(link_rd), .target_done_status(done_st),
		.target_init_status(init_st), .target_done_pin(done_pin), .target_init_pin(init_pin),
		.target_prog_b(prog_b), .target_mode_pins(mpins), .target_io_hiz(hiz),
		.target_flash_owner(owner), .link_enable(link_en), .done_led(led));
	frc_target_model i_frc_target_model (.clk_sys(clk_sys), .rst_b(rst_b),
		.target_prog_b(prog_b), .target_mode_pins(mpins), .target_done_pin(done_pin),
		.target_init_pin(init_pin));

	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Outputs are looked at on the falling edge, well after the update
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// Bounded wait: a load that never completes shows as a mismatch
	task automatic wait_done();
		for (int i = 0; i < 100 && done_st !== 1'b1; i++) begin
			step(1);
		end
		chk(done_st, 2'h1);
		chk(led, 2'h1);
		chk(init_st, 2'h1);
	endtask
	task automatic t_reset();
		step(2);
		chk(prog_b, 2'h1);
		chk(mpins, 2'h1);
		chk(owner, 2'h0);
		chk(isp_rd, 2'h0);
		chk(mode_rd, 2'h0);
		chk(link_en, 2'h1);
		chk(link_rd, 2'h1);
		chk(done_st, 2'h0);
		wait_done();
		$display("t_reset finished");
	endtask
	task automatic t_spi();
		link = 1'b0;
		step(2);
		chk(link_en, 2'h0);
		chk(owner, 2'h0);
		cmd = 1'b1;
		step(2);
		chk(prog_b, 2'h0);
		chk(hiz, 2'h1);
		chk(cmd_rd, 2'h1);
		chk(mpins, 2'h1);
		step(8);
		chk(done_st, 2'h0);
		chk(led, 2'h0);
		chk(init_st, 2'h0);
		chk(prog_b, 2'h0);
		cmd = 1'b0;
		step(2);
		chk(prog_b, 2'h1);
		chk(hiz, 2'h0);
		wait_done();
		// endpoint header restore is host work; nothing reaches this block
		link = 1'b1;
		step(2);
		chk(link_en, 2'h1);
		$display("t_spi finished");
	endtask
	task automatic t_par();
		mode_sel = 1'b1;
		cmd = 1'b1;
		step(2);
		chk(mpins, 2'h2);
		chk(mode_rd, 2'h1);
		cmd = 1'b0;
		step(2);
		mode_sel = 1'b0;
		isp = 1'b1;
		step(2);
		chk(mpins, 2'h2);
		chk(owner, 2'h1);
		chk(isp_rd, 2'h1);
		step(30);
		chk(done_st, 2'h0);
		cmd = 1'b1;
		step(2);
		chk(hiz, 2'h1);
		chk(mpins, 2'h1);
		isp = 1'b0;
		cmd = 1'b0;
		step(2);
		chk(prog_b, 2'h1);
		wait_done();
		$display("t_par finished");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#8000;
		bad_count++;
		$display("Watchdog expired");
		test_done();
	end
	initial begin
		bad_count = 0;
		total_checks = 0;
		rst_b = 1'b0;
		mode_sel = 1'b0;
		cmd = 1'b0;
		isp = 1'b0;
		link = 1'b1;
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		t_reset();
		t_spi();
		t_par();
		test_done();
	end
endmodule
